// ---- gxm_pkg.sv ----
// Purpose: constants for the gateway exchange memory
// Assumes: byte addresses 0..4999, modbus words are two bytes, high byte first
package gxm_pkg;
  localparam int unsigned GXM_MEM_BYTES = 5000;
  localparam int unsigned GXM_OUT_BASE = 3000;
  localparam int unsigned GXM_IN_DATA_END = 1599;
  localparam int unsigned GXM_IDENT_BASE = 1600;
  localparam int unsigned GXM_IDENT_SLOT = 20;
  localparam int unsigned GXM_NET_STATE = 1920;
  localparam int unsigned GXM_TX_CNT = 1921;
  localparam int unsigned GXM_RX_CNT = 1922;
  localparam int unsigned GXM_ERR_CNT = 1923;
  localparam int unsigned GXM_IDENT_STAT = 1944;
  localparam int unsigned GXM_CMD_STAT = 1960;
  localparam int unsigned GXM_CMD_STAT_END = 2119;
  localparam int unsigned GXM_PT_RX_LABEL = 2392;
  localparam int unsigned GXM_PT_RX_ERR = 2393;
  localparam int unsigned GXM_PT_RX_LEN = 2394;
  localparam int unsigned GXM_PT_RX_DATA = 2396;
  localparam int unsigned GXM_PT_MAX = 300;
  localparam int unsigned GXM_CNT_CLEAR = 4000;
  localparam int unsigned GXM_POLL_EN = 4001;
  localparam int unsigned GXM_TRIG_LABEL = 4002;
  localparam int unsigned GXM_TRIG_CMD = 4003;
  localparam int unsigned GXM_PT_TX_LABEL = 4270;
  localparam int unsigned GXM_PT_MODE = 4271;
  localparam int unsigned GXM_PT_TX_LEN = 4272;
  localparam int unsigned GXM_PT_TX_DATA = 4274;
  localparam int unsigned GXM_CLK_HZ = 200_000_000;
  localparam int unsigned GXM_BITS_PER_CHAR = 10;
  localparam int unsigned GXM_GAP_HALF_CHARS = 7; // 3.5 characters, in half characters
  localparam logic [7:0] GXM_PT_ON = 8'h01;
  typedef enum logic [1:0] {GXM_NET_IDLE, GXM_NET_SEND, GXM_NET_WAIT, GXM_NET_PROC} gxm_net_t;
  typedef enum logic [2:0] {GXM_ST_NONE, GXM_ST_OK, GXM_ST_PARITY, GXM_ST_NOANS,
                            GXM_ST_PROTO, GXM_ST_UNCONN} gxm_stat_t;
endpackage

// ---- gxm_exchange.sv ----
// Purpose: shared exchange memory between a modbus slave port and a field network engine
// Assumes: modbus framing, field transactions and the uart live outside; all on i_mclk
// Notes: modbus words map to two bytes, high byte at the lower byte address
module gxm_exchange
  import gxm_pkg::*;
#(
  parameter int unsigned BAUD = 19200,
  // 64-bit product: half characters times bits times clock overflows 32 bits
  parameter int unsigned GAP_CYCLES = 32'((64'(GXM_GAP_HALF_CHARS) * GXM_BITS_PER_CHAR
                                          * (GXM_CLK_HZ / 2)) / BAUD),
  parameter int unsigned SLAVES = 16
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // modbus register port: region 0 = input area, 1 = holding area
  input wire logic i_mb_rd,
  input wire logic i_mb_wr,
  input wire logic i_mb_region,
  input wire logic [10:0] i_mb_addr,
  input wire logic [15:0] i_mb_wdata,
  output logic [15:0] o_mb_rdata,
  output logic o_mb_rvalid,
  // field engine: byte writes into the input area, byte reads of the output area
  input wire logic i_fld_wr,
  input wire logic [12:0] i_fld_waddr,
  input wire logic [7:0] i_fld_wdata,
  input wire logic [12:0] i_fld_raddr,
  output logic [7:0] o_fld_rdata,
  // field engine: state, traffic events and command status
  input wire logic [1:0] i_net_state,
  input wire logic i_tx_evt,
  input wire logic i_rx_evt,
  input wire logic i_err_evt,
  input wire logic i_stat_wr,
  input wire logic i_stat_ident,
  input wire logic [7:0] i_stat_idx,
  input wire logic [2:0] i_stat_code,
  // field engine: identity read tracking
  input wire logic i_op_req,
  input wire logic [3:0] i_op_slave,
  input wire logic i_ident_done,
  output logic o_ident_needed,
  // field engine: control outputs
  output logic o_poll_enable,
  output logic o_trig_start,
  output logic [7:0] o_trig_cmd,
  output logic o_pt_enable,
  output logic o_pt_send,
  output logic [15:0] o_pt_len,
  // field engine: pass-through receive
  input wire logic i_pt_rx_valid,
  input wire logic [7:0] i_pt_rx_data,
  input wire logic i_pt_rx_done,
  input wire logic i_pt_timeout,
  // transparent mode: serial bytes in and out, field bytes in and out
  input wire logic i_transp_mode,
  input wire logic i_ser_rx_valid,
  input wire logic [7:0] i_ser_rx_data,
  output logic o_fwd_valid,
  output logic [7:0] o_fwd_data,
  output logic o_fwd_end,
  input wire logic i_fld_rx_valid,
  input wire logic [7:0] i_fld_rx_data,
  output logic o_ser_tx_valid,
  output logic [7:0] o_ser_tx_data
);

  // elaboration checks: refuse sizes the fixed byte map cannot hold
  if (BAUD == 0 || GAP_CYCLES == 0 || SLAVES == 0 || SLAVES > 16) begin : g_bad_params
    $error("gxm_exchange: unsupported parameter values");
  end
  // every slave's identity slot must end before the network state byte
  if (GXM_IDENT_BASE + SLAVES * GXM_IDENT_SLOT > GXM_NET_STATE) begin : g_bad_slots
    $error("gxm_exchange: identity slots overlap the status bytes");
  end
  // identity status bytes must end before the user command status
  if (GXM_IDENT_STAT + SLAVES > GXM_CMD_STAT) begin : g_bad_stat
    $error("gxm_exchange: identity status overlaps command status");
  end
  // the pass-through receive area must stay inside the input half
  if (GXM_PT_RX_DATA + GXM_PT_MAX > GXM_OUT_BASE) begin : g_bad_ptarea
    $error("gxm_exchange: pass-through area crosses into the output half");
  end

  localparam logic [12:0] A_OUT = 13'(GXM_OUT_BASE);
  localparam logic [12:0] A_TOP = 13'(GXM_MEM_BYTES - 1);

  // storage; the memory itself is not reset, only control state
  logic [7:0] mem [0:GXM_MEM_BYTES-1];
  logic [7:0] tx_cnt_reg, rx_cnt_reg, err_cnt_reg;
  logic [1:0] net_reg;
  logic poll_reg;
  logic [7:0] pt_label_reg, pt_err_reg;
  logic [15:0] pt_len_reg;
  logic [8:0] pt_idx_reg;
  logic [SLAVES-1:0] ident_ok_reg;
  logic [31:0] gap_cnt_reg;
  logic gap_arm_reg;

  // modbus byte addresses of the word being accessed
  logic [12:0] mb_hi, mb_lo;
  logic mb_in_range;
  always_comb begin
    mb_hi = i_mb_region ? 13'(A_OUT + {i_mb_addr, 1'b0}) : 13'({i_mb_addr, 1'b0});
    mb_lo = 13'(mb_hi + 13'h0001);
    if (i_mb_region) begin
      mb_in_range = (mb_lo <= A_TOP);
    end else begin
      mb_in_range = (mb_lo < A_OUT);
    end
  end

  // write-side change detection on the control bytes
  // limitation: the memory powers up unknown, so a label's first write after power-up may
  // or may not count as a change; hosts prime each label once before relying on it
  logic wr_ok;
  logic [7:0] wb_hi, wb_lo;
  logic hit_clr, hit_poll, hit_tlab, hit_tcmd, hit_slab, hit_mode;
  logic clr_cnt, trig_fire, send_fire;
  always_comb begin
    wr_ok = i_mb_wr && i_mb_region && mb_in_range;
    wb_hi = i_mb_wdata[15:8];
    wb_lo = i_mb_wdata[7:0];
    hit_clr = wr_ok && (mb_hi == 13'(GXM_CNT_CLEAR));
    hit_poll = hit_clr; // 4001 is the low byte of the same word
    hit_tlab = wr_ok && (mb_hi == 13'(GXM_TRIG_LABEL));
    hit_tcmd = hit_tlab;
    hit_slab = wr_ok && (mb_hi == 13'(GXM_PT_TX_LABEL));
    hit_mode = hit_slab;
    clr_cnt = hit_clr && (wb_hi != mem[GXM_CNT_CLEAR]);
    trig_fire = hit_tlab && (wb_hi != mem[GXM_TRIG_LABEL]);
    // send on label change, only with the mode on (mode as written this cycle)
    send_fire = hit_slab && (wb_hi != mem[GXM_PT_TX_LABEL]) && (wb_lo == GXM_PT_ON);
  end

  // byte view of the memory with the live status bytes overlaid
  function automatic logic [7:0] view(input logic [12:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a == 13'(GXM_NET_STATE)) begin
      v = {6'h00, net_reg};
    end else if (a == 13'(GXM_TX_CNT)) begin
      v = tx_cnt_reg;
    end else if (a == 13'(GXM_RX_CNT)) begin
      v = rx_cnt_reg;
    end else if (a == 13'(GXM_ERR_CNT)) begin
      v = err_cnt_reg;
    // polling reads as 1 or 0
    end else if (a == 13'(GXM_POLL_EN)) begin
      v = {7'h00, poll_reg};
    end else if (a == 13'(GXM_PT_RX_LABEL)) begin
      v = pt_label_reg;
    end else if (a == 13'(GXM_PT_RX_ERR)) begin
      v = pt_err_reg;
    end else if (a == 13'(GXM_PT_RX_LEN)) begin
      v = pt_len_reg[15:8];
    end else if (a == 13'(GXM_PT_RX_LEN + 1)) begin
      v = pt_len_reg[7:0];
    end else if (a <= A_TOP) begin
      v = mem[a];
    end
    return v;
  endfunction

  // one memory, split into input half and output half
  // field input data written by the engine, triggered replies land here too
  always_ff @(posedge i_mclk) begin
    // modbus writes reach only the output and control half
    if (wr_ok) begin
      mem[mb_hi] <= wb_hi;
      mem[mb_lo] <= wb_lo;
    end
    // field writes reach only the input half; the engine picks the area per command
    if (i_fld_wr && i_fld_waddr < A_OUT) begin
      mem[i_fld_waddr] <= i_fld_wdata;
    end
    // status bytes; codes as defined by the enum
    if (i_stat_wr) begin
      if (i_stat_ident && i_stat_idx < 8'(SLAVES)) begin
        mem[13'(GXM_IDENT_STAT) + 13'(i_stat_idx)] <= {5'h00, i_stat_code};
      end else if (!i_stat_ident && i_stat_idx <= 8'(GXM_CMD_STAT_END - GXM_CMD_STAT)) begin
        mem[13'(GXM_CMD_STAT) + 13'(i_stat_idx)] <= {5'h00, i_stat_code};
      end
    end
    // received frame stored contiguously; not while the mode is off
    if (o_pt_enable && i_pt_rx_valid && pt_idx_reg < 9'(GXM_PT_MAX)) begin
      mem[13'(GXM_PT_RX_DATA) + 13'(pt_idx_reg)] <= i_pt_rx_data;
    end
  end

  // modbus read answer, one cycle after the request
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_mb_rdata <= 16'h0000;
      o_mb_rvalid <= 1'b0;
    end else begin
      o_mb_rvalid <= i_mb_rd;
      if (i_mb_rd) begin
        o_mb_rdata <= mb_in_range ? {view(mb_hi), view(mb_lo)} : 16'h0000;
      end
    end
  end

  // field read port of the output area, registered
  // input-area addresses read as zero so the engine cannot echo stale input bytes
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_fld_rdata <= 8'h00;
    end else if (i_fld_raddr >= A_OUT && i_fld_raddr <= A_TOP) begin
      o_fld_rdata <= mem[i_fld_raddr];
    end else begin
      o_fld_rdata <= 8'h00;
    end
  end

  // network state mirror
  // registered copy: if the engine moves on mid-read, the byte still shows one whole value
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      net_reg <= GXM_NET_IDLE;
    end else begin
      net_reg <= i_net_state;
    end
  end

  // counters count their events; a clear still keeps the event of that cycle
  // counters wrap at 255; a host works with differences between two reads
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      tx_cnt_reg <= 8'h00;
      rx_cnt_reg <= 8'h00;
      err_cnt_reg <= 8'h00;
    end else if (clr_cnt) begin
      tx_cnt_reg <= {7'h00, i_tx_evt};
      rx_cnt_reg <= {7'h00, i_rx_evt};
      err_cnt_reg <= {7'h00, i_err_evt};
    end else begin
      tx_cnt_reg <= tx_cnt_reg + {7'h00, i_tx_evt};
      rx_cnt_reg <= rx_cnt_reg + {7'h00, i_rx_evt};
      err_cnt_reg <= err_cnt_reg + {7'h00, i_err_evt};
    end
  end

  // polling enable; values other than 0 and 1 leave it alone
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      poll_reg <= 1'b0;
    end else if (hit_poll && wb_lo == 8'h01) begin
      poll_reg <= 1'b1;
    end else if (hit_poll && wb_lo == 8'h00) begin
      poll_reg <= 1'b0;
    end
  end
  assign o_poll_enable = poll_reg;

  // one start pulse with the number written alongside the label
  // a word write carries number and label together, so the number is always fresh
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_trig_start <= 1'b0;
      o_trig_cmd <= 8'h00;
    end else begin
      o_trig_start <= trig_fire;
      if (trig_fire) begin
        o_trig_cmd <= hit_tcmd ? wb_lo : mem[GXM_TRIG_CMD];
      end
    end
  end

  // mode flag follows byte 4271 holding exactly one
  // any write of the label word updates the mode as well, as both bytes share one word
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_pt_enable <= 1'b0;
    end else if (hit_mode) begin
      o_pt_enable <= (wb_lo == GXM_PT_ON);
    end
  end

  // send pulse with the stored frame length; data is read at 4274 on
  // the length is copied at the send, so rewriting it later cannot alter a frame in flight
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_pt_send <= 1'b0;
      o_pt_len <= 16'h0000;
    end else begin
      // send_fire already excludes the disabled mode
      o_pt_send <= send_fire;
      if (send_fire) begin
        o_pt_len <= {mem[GXM_PT_TX_LEN], mem[GXM_PT_TX_LEN + 1]};
      end
    end
  end

  // length and label update at frame end; a timeout adds one error
  // bytes past the area are dropped and the index stops, so the length shows what was kept
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      pt_idx_reg <= 9'h000;
      pt_len_reg <= 16'h0000;
      pt_label_reg <= 8'h00;
      pt_err_reg <= 8'h00;
    end else if (o_pt_enable) begin
      if (i_pt_rx_done) begin
        pt_len_reg <= 16'(pt_idx_reg);
        pt_label_reg <= pt_label_reg + 8'h01;
        pt_idx_reg <= 9'h000;
      end else if (i_pt_rx_valid && pt_idx_reg < 9'(GXM_PT_MAX)) begin
        pt_idx_reg <= pt_idx_reg + 9'h001;
      end
      if (i_pt_timeout) begin
        pt_err_reg <= pt_err_reg + 8'h01;
      end
    end else begin
      // a frame cut off by disabling is dropped
      pt_idx_reg <= 9'h000;
    end
  end

  // a slave needs the identity read until its first one completes
  // a completion without a standing request is not recorded: the slave number is unknown
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      ident_ok_reg <= '0;
    end else if (i_op_req && i_ident_done && 32'(i_op_slave) < SLAVES) begin
      ident_ok_reg[i_op_slave] <= 1'b1;
    end
  end
  assign o_ident_needed = i_op_req && (32'(i_op_slave) < SLAVES) && !ident_ok_reg[i_op_slave];

  // transparent mode forwards bytes unmodified in both directions
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_fwd_valid <= 1'b0;
      o_fwd_data <= 8'h00;
      o_ser_tx_valid <= 1'b0;
      o_ser_tx_data <= 8'h00;
    end else begin
      o_fwd_valid <= i_transp_mode && i_ser_rx_valid;
      if (i_ser_rx_valid) begin
        o_fwd_data <= i_ser_rx_data;
      end
      o_ser_tx_valid <= i_transp_mode && i_fld_rx_valid;
      if (i_fld_rx_valid) begin
        o_ser_tx_data <= i_fld_rx_data;
      end
    end
  end

  // idle gap of 3.5 characters ends a frame; one end pulse per frame
  // the counter disarms at the end, so a long silence gives a single end pulse
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      gap_cnt_reg <= 32'h0000_0000;
      gap_arm_reg <= 1'b0;
      o_fwd_end <= 1'b0;
    end else begin
      o_fwd_end <= 1'b0;
      if (!i_transp_mode) begin
        gap_arm_reg <= 1'b0;
        gap_cnt_reg <= 32'h0000_0000;
      end else if (i_ser_rx_valid) begin
        gap_arm_reg <= 1'b1;
        gap_cnt_reg <= 32'h0000_0000;
      end else if (gap_arm_reg) begin
        if (gap_cnt_reg >= GAP_CYCLES - 1) begin
          gap_arm_reg <= 1'b0;
          o_fwd_end <= 1'b1;
        end else begin
          gap_cnt_reg <= gap_cnt_reg + 32'h0000_0001;
        end
      end
    end
  end

endmodule

// ---- gxm_exchange_monitor.sv ----
// Purpose: concurrent checks on the exchange memory ports
// Assumes: one clock domain, asynchronous active-high reset
// Notes: the frame gap length comes from the bound instance
module gxm_exchange_monitor
  import gxm_pkg::*;
#(
  parameter int unsigned GAP_CYCLES = 20
) (
  // clock, reset and register port
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_mb_rd,
  input wire logic i_mb_wr,
  input wire logic i_mb_region,
  input wire logic [10:0] i_mb_addr,
  input wire logic [15:0] i_mb_wdata,
  input wire logic o_mb_rvalid,
  // control outputs and their causes
  input wire logic i_op_req,
  input wire logic o_ident_needed,
  input wire logic o_poll_enable,
  input wire logic o_trig_start,
  input wire logic [7:0] o_trig_cmd,
  input wire logic o_pt_enable,
  input wire logic o_pt_send,
  // transparent serial path
  input wire logic i_transp_mode,
  input wire logic i_ser_rx_valid,
  input wire logic [7:0] i_ser_rx_data,
  input wire logic o_fwd_valid,
  input wire logic [7:0] o_fwd_data,
  input wire logic o_fwd_end
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);

  // holding-area word write, shared by the control checks
  logic hw;
  assign hw = i_mb_wr && i_mb_region;

  // idle cycles since the last serial byte; saturates so a long idle never wraps
  int unsigned idle_reg;
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      idle_reg <= 0;
    end else if (i_ser_rx_valid) begin
      idle_reg <= 0;
    end else if (idle_reg < GAP_CYCLES + 4) begin
      idle_reg <= idle_reg + 1;
    end
  end

  a_read_answer: assert property (i_mb_rd |=> o_mb_rvalid)
    else $error("read not answered");
  a_rvalid_cause: assert property (o_mb_rvalid |-> $past(i_mb_rd))
    else $error("answer without read");
  a_trig_cause: assert property (o_trig_start |-> $past(hw && i_mb_addr == 11'h1f5)
    && o_trig_cmd == $past(i_mb_wdata[7:0])) else $error("trigger without label write");
  a_pt_send_cause: assert property (o_pt_send |->
    $past(hw && i_mb_addr == 11'h27b && i_mb_wdata[7:0] == 8'h01)) else $error("stray send");
  a_pt_mode_upd: assert property (hw && i_mb_addr == 11'h27b |=>
    o_pt_enable == ($past(i_mb_wdata[7:0]) == 8'h01)) else $error("mode flag wrong");
  a_poll_upd: assert property (hw && i_mb_addr == 11'h1f4 && i_mb_wdata[7:1] == 7'h00
    |=> o_poll_enable == $past(i_mb_wdata[0])) else $error("polling flag wrong");
  a_ident_gate: assert property (o_ident_needed |-> i_op_req)
    else $error("identity asked without request");
  a_fwd_follow: assert property (i_transp_mode && i_ser_rx_valid |=>
    o_fwd_valid && o_fwd_data == $past(i_ser_rx_data)) else $error("byte not forwarded");
  a_gap_time: assert property (o_fwd_end |->
    idle_reg inside {[GAP_CYCLES - 1:GAP_CYCLES + 1]}) else $error("frame end off time");

  // main scenarios reached
  c_trig: cover property (o_trig_start);
  c_send: cover property (o_pt_send);
  c_end: cover property (o_fwd_end);
endmodule

// ---- gxm_mb_master.sv ----
// Purpose: register-port master standing in for the serial host
// Assumes: request launched at a falling edge, taken at the next rising edge
// Notes: idle address and data are inverted so stale values are never trusted
module gxm_mb_master (
  // clock and answer
  input wire logic i_mclk,
  input wire logic [15:0] i_rdata,
  input wire logic i_rvalid,
  // request
  output logic o_rd,
  output logic o_wr,
  output logic o_region,
  output logic [10:0] o_addr,
  output logic [15:0] o_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle at time zero
  initial begin
    o_rd = 0;
    o_wr = 0;
    o_region = 0;
    o_addr = '0;
    o_wdata = '0;
  end

  // one word access, single-register style; answer taken after the rising edge
  task automatic xfer(input logic wr, input logic rg, input logic [10:0] a,
                      input logic [15:0] d, output logic [15:0] q, output logic ok);
    @(negedge i_mclk);
    o_rd = !wr;
    o_wr = wr;
    o_region = rg;
    o_addr = a;
    o_wdata = d;
    @(negedge i_mclk);
    q = i_rdata;
    ok = wr || i_rvalid;
    o_rd = 0;
    o_wr = 0;
    o_addr = ~a;
    o_wdata = ~d;
  endtask
endmodule

// ---- tb_fieldbus_gateway_exchange_memory.sv ----
// Purpose: self-checking bench for the gateway exchange memory
// Assumes: inputs change at the falling edge, short frame gap for speed
// Notes: reads go through the host model, engine inputs are driven here
module tb_fieldbus_gateway_exchange_memory;
  timeunit 1ns;
  timeprecision 1ps;
  import gxm_pkg::*;
  // 35 bit times at this rate last 35 * 200 MHz / 350 MBd = 20 clocks
  localparam int unsigned SIM_BAUD = 350_000_000;
  localparam int unsigned GAP = 20;
  logic i_mclk = 0, i_rst = 1, i_mb_rd, i_mb_wr, i_mb_region, o_mb_rvalid;
  logic [10:0] i_mb_addr;
  logic [15:0] i_mb_wdata, o_mb_rdata, o_pt_len;
  logic i_fld_wr = 0, i_tx_evt = 0, i_rx_evt = 0, i_err_evt = 0, i_stat_wr = 0;
  logic i_stat_ident = 0, i_op_req = 0, i_ident_done = 0, i_pt_rx_valid = 0;
  logic i_pt_rx_done = 0, i_pt_timeout = 0, i_transp_mode = 0, i_ser_rx_valid = 0;
  logic i_fld_rx_valid = 0, o_ident_needed, o_poll_enable, o_trig_start, o_pt_enable;
  logic o_pt_send, o_fwd_valid, o_fwd_end, o_ser_tx_valid;
  logic [12:0] i_fld_waddr = 0, i_fld_raddr = 0;
  logic [7:0] i_fld_wdata = 0, o_fld_rdata, i_stat_idx = 0, o_trig_cmd, i_pt_rx_data = 0;
  logic [7:0] i_ser_rx_data = 0, o_fwd_data, i_fld_rx_data = 0, o_ser_tx_data;
  logic [1:0] i_net_state = 0;
  logic [2:0] i_stat_code = 0;
  logic [3:0] i_op_slave = 0;
  int err_count = 0, num_checks = 0;

  // clock and reset
  always #2.5 i_mclk = ~i_mclk;

  gxm_exchange #(.BAUD(SIM_BAUD)) dut (.i_mclk, .i_rst, .i_mb_rd, .i_mb_wr, .i_mb_region,
    .i_mb_addr, .i_mb_wdata, .o_mb_rdata, .o_mb_rvalid, .i_fld_wr, .i_fld_waddr, .i_fld_wdata,
    .i_fld_raddr, .o_fld_rdata, .i_net_state, .i_tx_evt, .i_rx_evt, .i_err_evt, .i_stat_wr,
    .i_stat_ident, .i_stat_idx, .i_stat_code, .i_op_req, .i_op_slave, .i_ident_done,
    .o_ident_needed, .o_poll_enable, .o_trig_start, .o_trig_cmd, .o_pt_enable, .o_pt_send,
    .o_pt_len, .i_pt_rx_valid, .i_pt_rx_data, .i_pt_rx_done, .i_pt_timeout, .i_transp_mode,
    .i_ser_rx_valid, .i_ser_rx_data, .o_fwd_valid, .o_fwd_data, .o_fwd_end, .i_fld_rx_valid,
    .i_fld_rx_data, .o_ser_tx_valid, .o_ser_tx_data);
  gxm_mb_master u_host (.i_mclk, .i_rdata(o_mb_rdata), .i_rvalid(o_mb_rvalid), .o_rd(i_mb_rd),
    .o_wr(i_mb_wr), .o_region(i_mb_region), .o_addr(i_mb_addr), .o_wdata(i_mb_wdata));

  // comparisons
  task automatic chk_w(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_b(input logic got, input logic exp);
    chk_w({15'h0000, got}, {15'h0000, exp});
  endtask
  task automatic rd(input logic rg, input logic [10:0] a, input logic [15:0] exp);
    logic [15:0] q;
    logic ok;
    u_host.xfer(1'b0, rg, a, 16'h0000, q, ok);
    chk_b(ok, 1'b1);
    chk_w(q, exp);
  endtask
  task automatic wr(input logic [10:0] a, input logic [15:0] d);
    logic [15:0] q;
    logic ok;
    u_host.xfer(1'b1, 1'b1, a, d, q, ok);
  endtask
  task automatic fld(input logic [12:0] a, input logic [7:0] d);
    @(negedge i_mclk);
    i_fld_wr = 1;
    i_fld_waddr = a;
    i_fld_wdata = d;
    @(negedge i_mclk);
    i_fld_wr = 0;
  endtask
  task automatic pt_byte(input logic [7:0] d);
    @(negedge i_mclk);
    i_pt_rx_valid = 1;
    i_pt_rx_data = d;
    @(negedge i_mclk);
    i_pt_rx_valid = 0;
    i_pt_rx_done = 1;
    @(negedge i_mclk);
    i_pt_rx_done = 0;
  endtask

  // input area words, output area and refused engine write
  task automatic t_data();
    wr(11'h0000, 16'h1234);
    fld(13'h0002, 8'h3c);
    fld(13'h0003, 8'ha5);
    fld(13'h0bb8, 8'hff);
    i_fld_raddr = 13'h0bb8;
    @(negedge i_mclk);
    chk_w({8'h00, o_fld_rdata}, 16'h0012);
    rd(1'b1, 11'h0000, 16'h1234);
    rd(1'b0, 11'h0001, 16'h3ca5);
    rd(1'b0, 11'h05dc, 16'h0000);
  endtask

  // state, counters, clear on change, polling flag
  task automatic t_status();
    wr(11'h01f4, 16'h0000);
    i_net_state = 2'h2;
    for (int k = 0; k < 3; k++) begin
      @(negedge i_mclk);
      i_tx_evt = 1;
      i_rx_evt = (k == 0);
      i_err_evt = (k < 2);
      @(negedge i_mclk);
      {i_tx_evt, i_rx_evt, i_err_evt} = 3'h0;
    end
    rd(1'b0, 11'h03c0, 16'h0203);
    rd(1'b0, 11'h03c1, 16'h0102);
    wr(11'h01f4, 16'h0501);
    chk_b(o_poll_enable, 1'b1);
    rd(1'b0, 11'h03c0, 16'h0200);
    rd(1'b0, 11'h03c1, 16'h0000);
    rd(1'b1, 11'h01f4, 16'h0501);
    wr(11'h01f4, 16'h0500);
    chk_b(o_poll_enable, 1'b0);
  endtask

  // every status code, user and identity slots
  task automatic t_codes();
    for (int k = 0; k < 8; k++) begin
      @(negedge i_mclk);
      i_stat_wr = 1;
      i_stat_ident = (k > 5);
      i_stat_idx = (k > 5) ? 8'(k - 6) : 8'(k);
      i_stat_code = (k == 6) ? 3'h3 : (k == 7) ? 3'h5 : 3'(k);
    end
    @(negedge i_mclk);
    i_stat_wr = 0;
    rd(1'b0, 11'h03d4, 16'h0001);
    rd(1'b0, 11'h03d5, 16'h0203);
    rd(1'b0, 11'h03d6, 16'h0405);
    rd(1'b0, 11'h03cc, 16'h0305);
  endtask

  // host writes the number and a new label in one word; same label again is no trigger
  task automatic t_trig();
    wr(11'h01f5, 16'h0000);
    wr(11'h01f5, 16'ha107);
    chk_b(o_trig_start, 1'b1);
    chk_w({8'h00, o_trig_cmd}, 16'h0007);
    wr(11'h01f5, 16'ha109);
    chk_b(o_trig_start, 1'b0);
  endtask

  // pass-through off then on, receive, timeout; host reads label and errors first
  task automatic t_pt();
    rd(1'b0, 11'h04ac, 16'h0000);
    wr(11'h027c, 16'h0003);
    wr(11'h027b, 16'h1100);
    chk_b(o_pt_send, 1'b0);
    chk_b(o_pt_enable, 1'b0);
    pt_byte(8'h77);
    rd(1'b0, 11'h04ac, 16'h0000);
    wr(11'h027b, 16'h2201);
    chk_b(o_pt_send, 1'b1);
    chk_w(o_pt_len, 16'h0003);
    chk_b(o_pt_enable, 1'b1);
    @(negedge i_mclk);
    i_pt_rx_valid = 1;
    i_pt_rx_data = 8'hab;
    pt_byte(8'hcd);
    rd(1'b0, 11'h04ac, 16'h0100);
    rd(1'b0, 11'h04ad, 16'h0002);
    rd(1'b0, 11'h04ae, 16'habcd);
    @(negedge i_mclk);
    i_pt_timeout = 1;
    @(negedge i_mclk);
    i_pt_timeout = 0;
    rd(1'b0, 11'h04ac, 16'h0101);
  endtask

  // transparent echo both ways and frame end after the idle gap
  task automatic t_transp();
    int n;
    i_transp_mode = 1;
    @(negedge i_mclk);
    i_fld_rx_valid = 1;
    i_fld_rx_data = 8'hc3;
    @(negedge i_mclk);
    i_fld_rx_valid = 0;
    chk_b(o_ser_tx_valid, 1'b1);
    chk_w({8'h00, o_ser_tx_data}, 16'h00c3);
    i_ser_rx_valid = 1;
    i_ser_rx_data = 8'h5a;
    @(negedge i_mclk);
    i_ser_rx_valid = 0;
    chk_w({7'h00, o_fwd_valid, o_fwd_data}, 16'h015a);
    n = 0;
    while (!o_fwd_end && n < GAP + 5) begin
      @(negedge i_mclk);
      n++;
    end
    chk_b(n >= GAP - 1 && n <= GAP + 1, 1'b1);
  endtask

  // identity read needed once per slave
  task automatic t_ident();
    @(negedge i_mclk);
    i_op_req = 1;
    i_op_slave = 4'h3;
    #1 chk_b(o_ident_needed, 1'b1);
    @(negedge i_mclk);
    i_ident_done = 1;
    @(negedge i_mclk);
    i_ident_done = 0;
    chk_b(o_ident_needed, 1'b0);
    i_op_slave = 4'h4;
    #1 chk_b(o_ident_needed, 1'b1);
    @(negedge i_mclk);
    i_op_req = 0;
  endtask

  task automatic tally_and_finish();
    if (err_count == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (3) @(negedge i_mclk);
    i_rst = 0;
    t_data();
    t_status();
    t_codes();
    t_trig();
    t_pt();
    t_transp();
    t_ident();
    tally_and_finish();
  end

  // watchdog, far beyond the roughly 120 cycles the tests need
  initial begin
    #20000;
    err_count++;
    tally_and_finish();
  end
endmodule

bind gxm_exchange gxm_exchange_monitor #(.GAP_CYCLES(GAP_CYCLES)) u_mon (.i_mclk, .i_rst,
  .i_mb_rd, .i_mb_wr, .i_mb_region, .i_mb_addr, .i_mb_wdata, .o_mb_rvalid, .i_op_req,
  .o_ident_needed, .o_poll_enable, .o_trig_start, .o_trig_cmd, .o_pt_enable, .o_pt_send,
  .i_transp_mode, .i_ser_rx_valid, .i_ser_rx_data, .o_fwd_valid, .o_fwd_data, .o_fwd_end);
